// ==== logic/lsx_pkg.sv ====
package lsx_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [7:0] OFS_CMD       = 8'h00;
  localparam logic [7:0] OFS_ACC       = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_PRESCALE  = 8'h0c;
  localparam logic [7:0] OFS_PC        = 8'h10;
  localparam logic [7:0] OFS_STACK     = 8'h14;
  localparam logic [7:0] OFS_WATCHDOG  = 8'h18;
  localparam logic [7:0] OFS_WAKE      = 8'h1c;
  localparam logic [7:0] OFS_FILE_BASE = 8'h80;

  // Field positions and widths
  localparam int STAT_BUSY_BIT  = 8;
  localparam int STAT_SLEEP_BIT = 9;
  localparam int WAKE_BIT       = 0;
  localparam int CMD_W          = 17;
  localparam int PC_W           = 9;

  // Values after reset, and the prescaler wrap value
  localparam logic [7:0]      ACC_RST   = 8'h00;
  localparam logic [7:0]      CFG_RST   = 8'h00;
  localparam logic [8:0]      PC_RST    = 9'h000;
  localparam logic [7:0]      WDT_RST   = 8'h00;
  localparam logic [7:0]      PRE_RST   = 8'h00;
  localparam logic [7:0]      FILE_RST  = 8'h00;
  localparam logic [5:0]      FLAGS_RST = 6'h18;
  localparam logic [7:0]      PRE_WRAP  = 8'hff;

  // Instruction codes carried in the command register
  typedef enum logic [2:0] {
    OP_NOP        = 3'b000,
    OP_LOAD_LIT   = 3'b001,
    OP_LOAD_CFG   = 3'b010,
    OP_RETURN_LIT = 3'b011,
    OP_POWER_DOWN = 3'b100,
    OP_ROTATE     = 3'b101,
    OP_SUBTRACT   = 3'b110,
    OP_RSVD       = 3'b111
  } lsx_op_t;

  // Command word: op [16:14], dest [13], file address [12:8], literal [7:0]
  typedef struct packed {
    lsx_op_t    op;
    logic       dest;
    logic [4:0] faddr;
    logic [7:0] lit;
  } lsx_cmd_t;

  // Status flags, carry in bit 0
  typedef struct packed {
    logic pin_change_wake_flag;
    logic timeout_status_n;
    logic power_down_status_n;
    logic zero;
    logic nibble_carry_flag;
    logic carry;
  } lsx_flags_t;

  // Result of one arithmetic path
  typedef struct packed {
    logic [7:0] value;
    logic       carry;
    logic       nibble;
    logic       zero;
  } lsx_alu_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_RETURN = 2'b01,
    ST_ASLEEP = 2'b10
  } lsx_state_t;

endpackage : lsx_pkg

// ==== logic/lsx_alu.sv ====
`timescale 1ns/1ps
// Rotate-left and subtract datapaths, purely combinational
module lsx_alu (
  input  wire logic [7:0]       file_val,
  input  wire logic [7:0]       acc_val,
  input  wire logic             carry_in,
  output lsx_pkg::lsx_alu_t     rot_res,
  output lsx_pkg::lsx_alu_t     sub_res
);

  logic [8:0] sum;
  logic [4:0] low_sum;

  // File minus accumulator as file plus inverted accumulator plus one
  always_comb begin
    sum     = {1'b0, file_val} + {1'b0, ~acc_val} + 9'h001;
    low_sum = {1'b0, file_val[3:0]} + {1'b0, ~acc_val[3:0]} + 5'h01;
    sub_res.value  = sum[7:0];
    sub_res.carry  = sum[8];                // High means no borrow
    sub_res.nibble = low_sum[4];
    sub_res.zero   = (sum[7:0] == 8'h00);
    // Bit 7 leaves into carry, old carry enters at bit 0
    rot_res.value  = {file_val[6:0], carry_in};
    rot_res.carry  = file_val[7];
    rot_res.nibble = 1'b0;
    rot_res.zero   = 1'b0;
  end

endmodule : lsx_alu

// ==== logic/lsx_exec.sv ====
`timescale 1ns/1ps
// Behaviour
// RULE1: Literal load puts the 8-bit immediate into the accumulator, flags untouched.
// RULE2: Config load copies the accumulator into the prescaler config, flags untouched.
// RULE3: Literal return loads accumulator with immediate and program counter from stack head.
// RULE4: Literal return takes two cycles; others here take one, power-down excepted.
// RULE5: Power-down clears the watchdog count and the watchdog prescaler.
// RULE6: Power-down sets timeout status high and power-down status low.
// RULE7: After power-down execution halts, clock stopped, until a wake-up arrives.
// RULE8: Rotate shifts a file register left through carry; only carry changes.
// RULE9: Subtract computes file minus accumulator and updates carry, nibble carry, zero.
// RULE10: Subtract and rotate write accumulator when dest is 0, file register when 1.
// RULE11: Rotate moves old bit 7 to carry and old carry to bit 0.
// RULE12: Carry means no borrow, nibble carry no low-nibble borrow, zero on zero result.
module lsx_exec (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             SLEEP_ACTIVE,
  output logic      [7:0]  PRESCALE_CFG
);

  logic                 wreq_r, wreq_nxt;
  logic [31:0]          rdata_r, rdata_nxt, rd_mux;
  logic                 wr_acc;
  lsx_pkg::lsx_state_t  state_r, state_nxt;
  lsx_pkg::lsx_cmd_t    cmd, cmd_last_r, cmd_last_nxt;
  lsx_pkg::lsx_flags_t  flags_r, flags_nxt;
  logic [7:0]           acc_r, acc_nxt;
  logic [7:0]           cfg_r, cfg_nxt;
  logic [8:0]           pc_r, pc_nxt;
  logic [8:0]           stack_head_r, stack_head_nxt;
  logic [7:0]           wdt_r, wdt_nxt;
  logic [7:0]           pre_r, pre_nxt;
  logic [7:0]           file_r   [32];
  logic [7:0]           file_nxt [32];
  logic                 sleep_r, sleep_nxt;
  logic                 cmd_go, wake_go;
  lsx_pkg::lsx_alu_t    rot_res, sub_res, res;

  assign AVS_WAITREQUEST = wreq_r;
  assign AVS_READDATA    = rdata_r;
  assign SLEEP_ACTIVE    = sleep_r;
  assign PRESCALE_CFG    = cfg_r;

  // An access is taken on the edge where waitrequest is seen low
  assign wr_acc  = AVS_WRITE && !wreq_r;
  assign cmd     = lsx_pkg::lsx_cmd_t'(AVS_WRITEDATA[lsx_pkg::CMD_W-1:0]);
  // Commands while busy or asleep are dropped; software polls the busy bit
  assign cmd_go  = wr_acc && (AVS_ADDRESS == lsx_pkg::OFS_CMD) && (state_r == lsx_pkg::ST_IDLE);
  assign wake_go = wr_acc && (AVS_ADDRESS == lsx_pkg::OFS_WAKE)
                   && AVS_WRITEDATA[lsx_pkg::WAKE_BIT] && (state_r == lsx_pkg::ST_ASLEEP);

  lsx_alu u_alu (
    .file_val (file_r[cmd.faddr]),
    .acc_val  (acc_r),
    .carry_in (flags_r.carry),
    .rot_res  (rot_res),
    .sub_res  (sub_res)
  );

  // Read decode; unmapped addresses read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (AVS_ADDRESS >= lsx_pkg::OFS_FILE_BASE) begin
      rd_mux[7:0] = file_r[AVS_ADDRESS[6:2]];
    end else begin
      unique case (AVS_ADDRESS)
        lsx_pkg::OFS_CMD:      rd_mux[lsx_pkg::CMD_W-1:0] = cmd_last_r;
        lsx_pkg::OFS_ACC:      rd_mux[7:0] = acc_r;
        lsx_pkg::OFS_STATUS: begin
          rd_mux[5:0] = flags_r;
          rd_mux[lsx_pkg::STAT_BUSY_BIT]  = (state_r == lsx_pkg::ST_RETURN);
          rd_mux[lsx_pkg::STAT_SLEEP_BIT] = sleep_r;
        end
        lsx_pkg::OFS_PRESCALE: rd_mux[7:0] = cfg_r;
        lsx_pkg::OFS_PC:       rd_mux[lsx_pkg::PC_W-1:0] = pc_r;
        lsx_pkg::OFS_STACK:    rd_mux[lsx_pkg::PC_W-1:0] = stack_head_r;
        lsx_pkg::OFS_WATCHDOG: rd_mux[15:0] = {pre_r, wdt_r};
        default:               rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Bus handshake: one wait cycle, then the answer for exactly one edge
  always_comb begin
    wreq_nxt  = 1'b1;
    rdata_nxt = rdata_r;
    if ((AVS_READ || AVS_WRITE) && wreq_r) begin
      wreq_nxt  = 1'b0;
      rdata_nxt = rd_mux;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      wreq_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wreq_r  <= wreq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Core next state: software writes first, then the executing instruction
  always_comb begin
    state_nxt      = state_r;
    cmd_last_nxt   = cmd_last_r;
    flags_nxt      = flags_r;
    acc_nxt        = acc_r;
    cfg_nxt        = cfg_r;
    pc_nxt         = pc_r;
    stack_head_nxt = stack_head_r;
    wdt_nxt        = wdt_r;
    pre_nxt        = pre_r;
    file_nxt       = file_r;
    res            = sub_res;
    // Watchdog runs only while the core clock runs
    if (state_r != lsx_pkg::ST_ASLEEP) begin
      pre_nxt = pre_r + 8'h01;
      if (pre_r == lsx_pkg::PRE_WRAP) begin
        wdt_nxt = wdt_r + 8'h01;
      end
    end
    if (wr_acc) begin
      if (AVS_ADDRESS >= lsx_pkg::OFS_FILE_BASE) begin
        file_nxt[AVS_ADDRESS[6:2]] = AVS_WRITEDATA[7:0];
      end else if (AVS_ADDRESS == lsx_pkg::OFS_ACC) begin
        acc_nxt = AVS_WRITEDATA[7:0];
      end else if (AVS_ADDRESS == lsx_pkg::OFS_STACK) begin
        stack_head_nxt = AVS_WRITEDATA[lsx_pkg::PC_W-1:0];
      end else if (AVS_ADDRESS == lsx_pkg::OFS_STATUS) begin
        flags_nxt.carry             = AVS_WRITEDATA[0];
        flags_nxt.nibble_carry_flag = AVS_WRITEDATA[1];
        flags_nxt.zero              = AVS_WRITEDATA[2];
      end
    end
    unique case (state_r)
      lsx_pkg::ST_IDLE: begin
        if (cmd_go) begin
          cmd_last_nxt = cmd;
          unique case (cmd.op)
            lsx_pkg::OP_LOAD_LIT: acc_nxt = cmd.lit;                       // [RULE1]
            lsx_pkg::OP_LOAD_CFG: cfg_nxt = acc_r;                         // [RULE2]
            lsx_pkg::OP_RETURN_LIT: begin
              acc_nxt   = cmd.lit;                                         // [RULE3]
              state_nxt = lsx_pkg::ST_RETURN;                              // [RULE4]
            end
            lsx_pkg::OP_POWER_DOWN: begin
              wdt_nxt   = lsx_pkg::WDT_RST;                                // [RULE5]
              pre_nxt   = lsx_pkg::PRE_RST;                                // [RULE5]
              flags_nxt.timeout_status_n    = 1'b1;                        // [RULE6]
              flags_nxt.power_down_status_n = 1'b0;                        // [RULE6]
              state_nxt = lsx_pkg::ST_ASLEEP;                              // [RULE7]
            end
            lsx_pkg::OP_ROTATE, lsx_pkg::OP_SUBTRACT: begin
              if (cmd.op == lsx_pkg::OP_ROTATE) begin
                res             = rot_res;                                 // [RULE11]
                flags_nxt.carry = rot_res.carry;                           // [RULE8]
              end else begin
                flags_nxt.carry             = sub_res.carry;               // [RULE9] [RULE12]
                flags_nxt.nibble_carry_flag = sub_res.nibble;              // [RULE12]
                flags_nxt.zero              = sub_res.zero;                // [RULE12]
              end
              if (cmd.dest) begin
                file_nxt[cmd.faddr] = res.value;                           // [RULE10]
              end else begin
                acc_nxt = res.value;                                       // [RULE10]
              end
            end
            lsx_pkg::OP_NOP, lsx_pkg::OP_RSVD: begin
            end
          endcase
        end
      end
      lsx_pkg::ST_RETURN: begin
        // Second cycle: the return address takes effect
        pc_nxt    = stack_head_r;                                          // [RULE3]
        state_nxt = lsx_pkg::ST_IDLE;                                      // [RULE4]
      end
      lsx_pkg::ST_ASLEEP: begin
        // Nothing executes until software signals a wake-up
        if (wake_go) begin
          state_nxt = lsx_pkg::ST_IDLE;                                    // [RULE7]
        end
      end
      default: state_nxt = lsx_pkg::ST_IDLE;
    endcase
    sleep_nxt = (state_nxt == lsx_pkg::ST_ASLEEP);
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state_r      <= lsx_pkg::ST_IDLE;
      cmd_last_r   <= '0;
      flags_r      <= lsx_pkg::FLAGS_RST;
      acc_r        <= lsx_pkg::ACC_RST;
      cfg_r        <= lsx_pkg::CFG_RST;
      pc_r         <= lsx_pkg::PC_RST;
      stack_head_r <= lsx_pkg::PC_RST;
      wdt_r        <= lsx_pkg::WDT_RST;
      pre_r        <= lsx_pkg::PRE_RST;
      sleep_r      <= 1'b0;
      for (int i = 0; i < 32; i++) begin
        file_r[i] <= lsx_pkg::FILE_RST;
      end
    end else begin
      state_r      <= state_nxt;
      cmd_last_r   <= cmd_last_nxt;
      flags_r      <= flags_nxt;
      acc_r        <= acc_nxt;
      cfg_r        <= cfg_nxt;
      pc_r         <= pc_nxt;
      stack_head_r <= stack_head_nxt;
      wdt_r        <= wdt_nxt;
      pre_r        <= pre_nxt;
      sleep_r      <= sleep_nxt;
      file_r       <= file_nxt;
    end
  end

  // Checks on the executing core
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence s_issue_ret;
    cmd_go && (cmd.op == lsx_pkg::OP_RETURN_LIT);
  endsequence

  sequence s_ret_tail;
    (state_r == lsx_pkg::ST_RETURN) ##1 (state_r == lsx_pkg::ST_IDLE);
  endsequence

  sequence s_issue_sleep;
    cmd_go && (cmd.op == lsx_pkg::OP_POWER_DOWN);
  endsequence

  chk_literal_load: assert property ( // [RULE1]
    cmd_go && (cmd.op == lsx_pkg::OP_LOAD_LIT)
    |=> (acc_r == $past(cmd.lit)) && (flags_r == $past(flags_r)))
    else $error("literal load did not reach the accumulator");

  chk_config_copy: assert property ( // [RULE2]
    cmd_go && (cmd.op == lsx_pkg::OP_LOAD_CFG)
    |=> (PRESCALE_CFG == $past(acc_r)) && (flags_r == $past(flags_r)))
    else $error("config load did not copy the accumulator");

  chk_return_pc: assert property ( // [RULE3]
    s_issue_ret |=> (acc_r == $past(cmd.lit)) ##1 (pc_r == $past(stack_head_r)))
    else $error("literal return loaded wrong values");

  chk_return_two: assert property ( // [RULE4]
    s_issue_ret |=> s_ret_tail)
    else $error("literal return did not take two cycles");

  chk_single_cycle: assert property ( // [RULE4]
    cmd_go && (cmd.op inside {lsx_pkg::OP_LOAD_LIT, lsx_pkg::OP_LOAD_CFG,
                              lsx_pkg::OP_ROTATE, lsx_pkg::OP_SUBTRACT})
    |=> (state_r == lsx_pkg::ST_IDLE))
    else $error("single-cycle instruction left the core busy");

  chk_sleep_wdt: assert property ( // [RULE5]
    s_issue_sleep |=> (wdt_r == lsx_pkg::WDT_RST) && (pre_r == lsx_pkg::PRE_RST))
    else $error("power-down did not clear the watchdog");

  chk_sleep_status: assert property ( // [RULE6]
    s_issue_sleep |=> flags_r.timeout_status_n && !flags_r.power_down_status_n)
    else $error("power-down status bits wrong");

  // The clear lands on the issue edge, so the frozen value is the cleared one
  chk_sleep_halt: assert property ( // [RULE7]
    s_issue_sleep |=> (SLEEP_ACTIVE && (wdt_r == lsx_pkg::WDT_RST)
                       && (pre_r == lsx_pkg::PRE_RST)) [*3])
    else $error("core kept running after power-down");

  chk_rotate_bits: assert property ( // [RULE8] [RULE11]
    cmd_go && (cmd.op == lsx_pkg::OP_ROTATE) && !cmd.dest
    |=> (acc_r == {$past(file_r[cmd.faddr][6:0]), $past(flags_r.carry)})
        && (flags_r.carry == $past(file_r[cmd.faddr][7]))
        && (flags_r.zero == $past(flags_r.zero)))
    else $error("rotate through carry wrong");

  chk_sub_flags: assert property ( // [RULE9] [RULE12]
    cmd_go && (cmd.op == lsx_pkg::OP_SUBTRACT)
    |=> (flags_r.carry == ($past(file_r[cmd.faddr]) >= $past(acc_r)))
        && (flags_r.nibble_carry_flag == ($past(file_r[cmd.faddr][3:0]) >= $past(acc_r[3:0])))
        && (flags_r.zero == ($past(file_r[cmd.faddr]) == $past(acc_r))))
    else $error("subtract flags wrong");

  chk_dest_file: assert property ( // [RULE10]
    cmd_go && (cmd.op inside {lsx_pkg::OP_ROTATE, lsx_pkg::OP_SUBTRACT}) && cmd.dest
    // Expected value is rebuilt from the operands, not taken from the datapath
    |=> (acc_r == $past(acc_r))
        && (file_r[$past(cmd.faddr)] == (($past(cmd.op) == lsx_pkg::OP_ROTATE)
            ? {$past(file_r[cmd.faddr][6:0]), $past(flags_r.carry)}
            : 8'($past(file_r[cmd.faddr]) - $past(acc_r)))))
    else $error("file destination not honoured");

endmodule : lsx_exec

// ==== verification/lsx_exec_test.sv ====
`timescale 1ns/1ps
// Self-checking bench: every access goes over the Avalon-MM slave port
module lsx_exec_test;
  logic        clk_sys;
  logic        rst_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sleep_active;
  logic [7:0]  prescale_cfg;
  int          failures;
  int          check_count;
  int          cycles;
  logic [31:0] q;
  logic [7:0]  res;
  logic [7:0]  acc_v;
  logic [2:0]  ef;
  logic [7:0]  lits [3] = '{8'h00, 8'hff, 8'h5a};
  logic [4:0]  rfa  [4] = '{5'd0, 5'd31, 5'd7, 5'd12};
  logic [7:0]  rval [4] = '{8'h81, 8'h40, 8'hff, 8'h00};
  logic [3:0]  rcin = 4'b0110;
  logic [7:0]  sf   [5] = '{8'h10, 8'h05, 8'h00, 8'h38, 8'hab};
  logic [7:0]  sw   [5] = '{8'h01, 8'h05, 8'h01, 8'h12, 8'hcd};

  lsx_exec dut (
    .CLK_SYS         (clk_sys),
    .RST_N           (rst_n),
    .AVS_ADDRESS     (avs_address),
    .AVS_READ        (avs_read),
    .AVS_WRITE       (avs_write),
    .AVS_WRITEDATA   (avs_writedata),
    .AVS_READDATA    (avs_readdata),
    .AVS_WAITREQUEST (avs_waitrequest),
    .SLEEP_ACTIVE    (sleep_active),
    .PRESCALE_CFG    (prescale_cfg)
  );

  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;

  // Watchdog on the whole run; the tests need well under a thousand bus cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      stop_test();
    end
  end

  task stop_test;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One bus cycle; an idle edge first so strobes are never assigned twice in a step
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rdat);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    // Hold until an edge samples waitrequest low; only the run timeout ends a hang
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    // Read data is taken at the accepting edge, then the request is dropped
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask : wr

  task rdchk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, q);
    check(name, q & m, e);
  endtask : rdchk

  task cmd(input lsx_pkg::lsx_op_t op, input logic dst, input logic [4:0] fa,
           input logic [7:0] lit);
    lsx_pkg::lsx_cmd_t c;
    c = {op, dst, fa, lit};
    wr(lsx_pkg::OFS_CMD, {15'h0, c});
  endtask : cmd

  function automatic logic [7:0] fadr(input logic [4:0] fa);
    return lsx_pkg::OFS_FILE_BASE + {1'b0, fa, 2'b00};
  endfunction : fadr

  // Main sequence
  initial begin
    clk_sys       = 1'b0;
    rst_n         = 1'b0;
    avs_address   = 8'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    failures      = 0;
    check_count   = 0;
    cycles        = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk("status", lsx_pkg::OFS_STATUS, 32'h3ff, 32'h18);
    rdchk("acc", lsx_pkg::OFS_ACC, 32'hff, 32'h00);
    check("cfg port", {24'h0, prescale_cfg}, 32'h0);
    wr(8'h40, 32'hffffffff);
    rdchk("unmapped", 8'h40, 32'hffffffff, 32'h0);
    $display("test reset done");
    // Literal load over boundary values; reserved and no-op codes change nothing
    wr(lsx_pkg::OFS_STATUS, 32'h7);
    for (int i = 0; i < 3; i++) begin
      cmd(lsx_pkg::OP_LOAD_LIT, 1'b1, 5'd3, lits[i]);
      rdchk("acc", lsx_pkg::OFS_ACC, 32'hff, {24'h0, lits[i]});
      rdchk("status", lsx_pkg::OFS_STATUS, 32'h3ff, 32'h1f);
    end
    cmd(lsx_pkg::OP_NOP, 1'b0, 5'd0, 8'h11);
    cmd(lsx_pkg::OP_RSVD, 1'b0, 5'd0, 8'h22);
    rdchk("acc", lsx_pkg::OFS_ACC, 32'hff, 32'h5a);
    $display("test literal done");
    // Config load copies the accumulator
    wr(lsx_pkg::OFS_ACC, 32'ha5);
    cmd(lsx_pkg::OP_LOAD_CFG, 1'b0, 5'd0, 8'h00);
    rdchk("cfg reg", lsx_pkg::OFS_PRESCALE, 32'hff, 32'ha5);
    check("cfg port", {24'h0, prescale_cfg}, 32'ha5);
    rdchk("status", lsx_pkg::OFS_STATUS, 32'h3ff, 32'h1f);
    $display("test config done");
    // Return with literal, then a single-cycle instruction once acc, pc and status are read back
    wr(lsx_pkg::OFS_STACK, 32'h1a3);
    cmd(lsx_pkg::OP_RETURN_LIT, 1'b1, 5'd31, 8'h3c);
    rdchk("acc", lsx_pkg::OFS_ACC, 32'hff, 32'h3c);
    rdchk("pc", lsx_pkg::OFS_PC, 32'h1ff, 32'h1a3);
    rdchk("status", lsx_pkg::OFS_STATUS, 32'h3ff, 32'h1f);
    cmd(lsx_pkg::OP_LOAD_LIT, 1'b0, 5'd0, 8'h77);
    rdchk("acc", lsx_pkg::OFS_ACC, 32'hff, 32'h77);
    $display("test return done");
    // Rotate left through carry, both destinations, lowest and highest file address
    for (int i = 0; i < 4; i++) begin
      res = {rval[i][6:0], rcin[i]};
      ef  = {~rcin[i], rcin[i], rval[i][7]};
      wr(fadr(rfa[i]), {24'h0, rval[i]});
      wr(lsx_pkg::OFS_ACC, 32'h99);
      wr(lsx_pkg::OFS_STATUS, {29'h0, ~rcin[i], rcin[i], rcin[i]});
      cmd(lsx_pkg::OP_ROTATE, i[0], rfa[i], 8'h00);
      rdchk("acc", lsx_pkg::OFS_ACC, 32'hff, i[0] ? 32'h99 : {24'h0, res});
      rdchk("file", fadr(rfa[i]), 32'hff, {24'h0, i[0] ? res : rval[i]});
      rdchk("status", lsx_pkg::OFS_STATUS, 32'h3ff, {29'h3, ef});
    end
    $display("test rotate done");
    // Subtract; flags are preset to the opposite of the expected ones
    for (int i = 0; i < 5; i++) begin
      res = sf[i] - sw[i];
      ef  = {res == 8'h00, sf[i][3:0] >= sw[i][3:0], sf[i] >= sw[i]};
      wr(fadr(5'(i * 5 + 1)), {24'h0, sf[i]});
      wr(lsx_pkg::OFS_ACC, {24'h0, sw[i]});
      wr(lsx_pkg::OFS_STATUS, {29'h0, ~ef});
      cmd(lsx_pkg::OP_SUBTRACT, i[0], 5'(i * 5 + 1), 8'h00);
      acc_v = i[0] ? sw[i] : res;
      rdchk("acc", lsx_pkg::OFS_ACC, 32'hff, {24'h0, acc_v});
      rdchk("file", fadr(5'(i * 5 + 1)), 32'hff, {24'h0, i[0] ? res : sf[i]});
      rdchk("status", lsx_pkg::OFS_STATUS, 32'h3ff, {29'h3, ef});
    end
    $display("test subtract done");
    // Power-down clears the watchdog, sets status, halts until woken
    bus(1'b0, lsx_pkg::OFS_WATCHDOG, 32'h0, q);
    check("watchdog running", {31'h0, q[15:0] !== 16'h0}, 32'h1);
    cmd(lsx_pkg::OP_POWER_DOWN, 1'b0, 5'd0, 8'h00);
    // The sleep output is launched by the accepting edge; look once it has settled
    @(negedge clk_sys);
    check("sleep", {31'h0, sleep_active}, 32'h1);
    rdchk("watchdog", lsx_pkg::OFS_WATCHDOG, 32'hffff, 32'h0);
    rdchk("status", lsx_pkg::OFS_STATUS, 32'h3ff, {29'h42, ef});
    cmd(lsx_pkg::OP_LOAD_LIT, 1'b0, 5'd0, 8'hee);
    rdchk("acc", lsx_pkg::OFS_ACC, 32'hff, {24'h0, acc_v});
    rdchk("watchdog", lsx_pkg::OFS_WATCHDOG, 32'hffff, 32'h0);
    wr(lsx_pkg::OFS_WAKE, 32'h0);
    check("sleep", {31'h0, sleep_active}, 32'h1);
    wr(lsx_pkg::OFS_WAKE, 32'h1);
    @(negedge clk_sys);
    check("sleep", {31'h0, sleep_active}, 32'h0);
    cmd(lsx_pkg::OP_LOAD_LIT, 1'b0, 5'd0, 8'hee);
    rdchk("acc", lsx_pkg::OFS_ACC, 32'hff, 32'hee);
    $display("test power-down done");
    stop_test();
  end
endmodule : lsx_exec_test
